/* File: verilog/pifm_pkg.sv */
// Constants for the peripheral interrupt flag and mask block.
// Assumes a CPU core that takes vectored requests and reports the vector
// it took, and timer logic that delivers one-cycle event pulses.
package pifm_pkg;

  // Register offsets in the I/O space.
  localparam logic [5:0] TIMER_IRQ_FLAGS_OFS   = 6'h38;
  localparam logic [5:0] TIMER_IRQ_MASK_OFS    = 6'h39;
  localparam logic [5:0] EXTERNAL_IRQ_MASK_OFS = 6'h3B;
  localparam logic [5:0] EXTERNAL_IRQ_FLAGS_OFS = 6'h3A;
  localparam logic [5:0] CPU_CONTROL_REG_OFS   = 6'h35;

  // Reset values.
  localparam logic [7:0] REG_RESET = 8'h00;

  // Bit positions.
  localparam int EXT_ONE_BIT     = 7;
  localparam int EXT_ZERO_BIT    = 6;
  localparam int CNT1_OVF_BIT    = 7;
  localparam int CNT1_CMP_A_BIT  = 6;
  localparam int CNT1_CMP_B_BIT  = 5;
  localparam int CNT1_CAP_BIT    = 3;
  localparam int CNT0_OVF_BIT    = 1;

  // Writable bits of each register.
  localparam logic [7:0] EXT_MASK_BITS   = 8'hC0;
  localparam logic [7:0] TIMER_MASK_BITS = 8'hEA;
  localparam logic [7:0] CTRL_SENSE_BITS = 8'h0F;

  // Sense control encodings.
  localparam logic [1:0] SENSE_LOW  = 2'h0;
  localparam logic [1:0] SENSE_RSVD = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;

  // Vector word addresses of the served sources.
  localparam logic [4:0] VEC_EXT_ZERO = 5'h02;
  localparam logic [4:0] VEC_EXT_ONE  = 5'h04;
  localparam logic [4:0] VEC_CAPTURE  = 5'h06;
  localparam logic [4:0] VEC_CMP_A    = 5'h08;
  localparam logic [4:0] VEC_CMP_B    = 5'h0A;
  localparam logic [4:0] VEC_CNT1_OVF = 5'h0C;
  localparam logic [4:0] VEC_CNT0_OVF = 5'h0E;
  localparam logic [4:0] VEC_NONE     = 5'h00;

endpackage

/* File: verilog/pifm_top.sv */
// Interrupt flags, masks, global enable and priority select.
// Assumes pins and timer pulses synchronous to I_CLK; the core pulses
// I_IRQ_ACK with the vector it took and I_RETURN_FROM_IRQ on return.
`timescale 1ns/1ps
module pifm_top
(
  input  wire logic       I_CLK,
  input  wire logic       I_ARST_N,
  input  wire logic [5:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  output logic      [7:0] O_RDATA,
  input  wire logic       I_EXT_REQUEST_ONE,
  input  wire logic       I_EXT_REQUEST_ZERO,
  input  wire logic       I_CNT1_OVERFLOW,
  input  wire logic       I_CNT1_PWM_TURN,
  input  wire logic       I_CNT1_PWM_MODE,
  input  wire logic       I_CNT1_CMP_A_MATCH,
  input  wire logic       I_CNT1_CMP_B_MATCH,
  input  wire logic       I_CNT1_CAPTURE,
  input  wire logic       I_CNT0_OVERFLOW,
  input  wire logic       I_GLOBAL_EN_SET,
  input  wire logic       I_RETURN_FROM_IRQ,
  input  wire logic       I_IRQ_ACK,
  input  wire logic [4:0] I_ACK_VECTOR,
  output logic            O_IRQ_REQ,
  output logic      [4:0] O_IRQ_VECTOR,
  output logic            O_GLOBAL_EN
);

  // Register map, offsets in the six-bit I/O space:
  //   0x38 timer flags: bit7 counter1 overflow, bit6 compare A, bit5
  //        compare B, bit3 capture, bit1 counter0 overflow; writing one
  //        to a flag clears it, the other bits read zero.
  //   0x39 timer mask: enables at the same positions as the flags.
  //   0x3A external flags: bit7 external one, bit6 external zero.
  //   0x3B external mask: bit7 external one, bit6 external zero.
  //   0x35 control: bits 3:2 sense of external one, 1:0 of zero.
  // Unmapped offsets read zero and ignore writes, so the block can sit
  // on a shared I/O bus next to other register sets.
  //
  // Register port: writes land on the next edge; read data are
  // registered and stand only in the cycle after I_RD, zero otherwise,
  // so an OR-ed read bus needs no extra select.
  //
  // Sense codes per pin: 00 low level, 01 reserved and inert, 10 falling
  // edge, 11 rising edge. The reserved code decodes to nothing rather
  // than to an alias, so a stray write cannot arm a pin by accident.
  //
  // Request timing, counted in core clock edges:
  //   edge N    an event pulse or a pin edge is seen;
  //   edge N+1  the flag reads back as set;
  //   edge N+1  O_IRQ_REQ and O_IRQ_VECTOR rise, given mask and enable;
  //   edge A    the core samples the request and raises I_IRQ_ACK;
  //   edge A+1  the flag and the global enable clear together.
  // The request is held off in the cycle of the ack and drops at edge A+1,
  // so a core that looks again at once still sees it and must skip edge A+1.
  //
  // Same-cycle conflicts are settled as follows:
  //   a hardware set beats a software or ack clear of the same flag;
  //   an ack clear of the global enable beats a return or software set;
  //   an ack naming a source that is not pending only clears the enable.
  // Losing an event is worse than serving one twice, hence the first.
  //
  // Level mode keeps no flag at all: the request follows the pin, and an
  // ack cannot silence it. Firmware must release the pin, or change the
  // sense code, before returning, or the core is interrupted again.
  //
  // Reset clears every register but the pin history, every output and the enable. The pin
  // history resets high, matching an idle pulled-up pin, so a pin that
  // is low when reset lifts reads as a fall in the first cycle.
  //
  // Core handshake, as this block expects it:
  //   I_IRQ_ACK is a one-cycle pulse with the vector taken on
  //   I_ACK_VECTOR; the vector is ignored in every other cycle.
  //   I_RETURN_FROM_IRQ is a one-cycle pulse; the enable rises on the
  //   next edge and a further pending source shows two edges later.
  //   I_GLOBAL_EN_SET is the software write of the enable, used by a
  //   handler that wants to allow nesting.
  //
  // Counter1 overflow has two sources: the wrap pulse in normal mode and
  // the turn at zero in PWM mode. I_CNT1_PWM_MODE is a level and picks
  // one of them each cycle; the other pulse is ignored while unselected.
  //
  // Priority, highest first: external zero, external one, capture,
  // compare A, compare B, counter1 overflow, counter0 overflow. The
  // vector codes are word addresses and grow as priority falls.
  //
  // Limitations: event inputs are taken as one-cycle pulses; an input
  // held high for several cycles keeps setting its flag and so defeats a
  // clear. Pins are taken as already synchronous; a raw pad needs a
  // synchroniser in front of this block. O_GLOBAL_EN is a registered
  // copy and trails the internal enable by one cycle.

  // Software visible registers and the global enable.
  logic [7:0] ext_mask_q;
  logic [7:0] ext_flags_q;
  logic [7:0] tmr_mask_q;
  logic [7:0] tmr_flags_q;
  logic [7:0] ctrl_q;
  logic       gie_q;
  logic       gie_d;

  // Pin history and per-pin decode.
  logic [1:0] pin_q;
  logic [1:0] pin_fall;
  logic [1:0] pin_rise;
  logic [1:0] pin_event;
  logic [1:0] pin_level;
  logic [1:0] pins;

  // Set and clear terms of the flag registers.
  logic [7:0] tmr_event;
  logic [7:0] tmr_ack;
  logic [7:0] ext_ack;
  logic [7:0] wr_tmr_clr;
  logic [7:0] wr_ext_clr;

  // Request selection and read path.
  logic [6:0] src_req;
  logic       ext_one_req;
  logic       ext_zero_req;
  logic       take;
  logic [4:0] vec_d;
  logic       req_d;
  logic [7:0] rdata_d;

  assign pins = {I_EXT_REQUEST_ONE, I_EXT_REQUEST_ZERO};

  // Previous pin levels for edge detection; pins are sampled whatever
  // the port direction, so firmware can raise software interrupts.
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      pin_q <= 2'h3;
    else
      pin_q <= pins;
  end

  // Per pin sense decode: index 1 is external one, index 0 is zero.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sense
      logic [1:0] sense;
      assign sense         = ctrl_q[2*gi+1 -: 2];
      assign pin_fall[gi]  = pin_q[gi] & ~pins[gi];
      assign pin_rise[gi]  = ~pin_q[gi] & pins[gi];
      // Reserved code 01 produces no event and no level request.
      assign pin_event[gi] =
        (sense == pifm_pkg::SENSE_FALL) ? pin_fall[gi] :
        (sense == pifm_pkg::SENSE_RISE) ? pin_rise[gi] :
        1'b0;
      assign pin_level[gi] = (sense == pifm_pkg::SENSE_LOW) & ~pins[gi];
    end
  endgenerate

  // Timer event pulses placed at their flag positions.
  always_comb
  begin
    tmr_event = 8'h00;
    tmr_event[pifm_pkg::CNT1_OVF_BIT] =
      I_CNT1_PWM_MODE ? I_CNT1_PWM_TURN : I_CNT1_OVERFLOW;
    tmr_event[pifm_pkg::CNT1_CMP_A_BIT] = I_CNT1_CMP_A_MATCH;
    tmr_event[pifm_pkg::CNT1_CMP_B_BIT] = I_CNT1_CMP_B_MATCH;
    tmr_event[pifm_pkg::CNT1_CAP_BIT]   = I_CNT1_CAPTURE;
    tmr_event[pifm_pkg::CNT0_OVF_BIT]   = I_CNT0_OVERFLOW;
  end

  // Clear masks from software writes of one.
  assign wr_tmr_clr = (I_WR && I_ADDR == pifm_pkg::TIMER_IRQ_FLAGS_OFS) ?
                      (I_WDATA & pifm_pkg::TIMER_MASK_BITS) : 8'h00;
  assign wr_ext_clr = (I_WR && I_ADDR == pifm_pkg::EXTERNAL_IRQ_FLAGS_OFS) ?
                      (I_WDATA & pifm_pkg::EXT_MASK_BITS) : 8'h00;

  // Clear masks from the core taking a vector.
  always_comb
  begin
    tmr_ack = 8'h00;
    ext_ack = 8'h00;
    if (I_IRQ_ACK)
    begin
      unique case (I_ACK_VECTOR)
        pifm_pkg::VEC_EXT_ZERO: ext_ack[pifm_pkg::EXT_ZERO_BIT]   = 1'b1;
        pifm_pkg::VEC_EXT_ONE:  ext_ack[pifm_pkg::EXT_ONE_BIT]    = 1'b1;
        pifm_pkg::VEC_CAPTURE:  tmr_ack[pifm_pkg::CNT1_CAP_BIT]   = 1'b1;
        pifm_pkg::VEC_CMP_A:    tmr_ack[pifm_pkg::CNT1_CMP_A_BIT] = 1'b1;
        pifm_pkg::VEC_CMP_B:    tmr_ack[pifm_pkg::CNT1_CMP_B_BIT] = 1'b1;
        pifm_pkg::VEC_CNT1_OVF: tmr_ack[pifm_pkg::CNT1_OVF_BIT]   = 1'b1;
        pifm_pkg::VEC_CNT0_OVF: tmr_ack[pifm_pkg::CNT0_OVF_BIT]   = 1'b1;
        default: tmr_ack = 8'h00;
      endcase
    end
  end

  // Timer flags: set in every cycle their event input is high, so an input
  // held high re-flags after a clear; a set beats a same-cycle clear.
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      tmr_flags_q <= pifm_pkg::REG_RESET;
    else
      tmr_flags_q <= ((tmr_flags_q & ~(wr_tmr_clr | tmr_ack))
                      | tmr_event) & pifm_pkg::TIMER_MASK_BITS;
  end

  // External flags are set on edges only; level mode keeps no flag.
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      ext_flags_q <= pifm_pkg::REG_RESET;
    else
    begin
      ext_flags_q <= ((ext_flags_q & ~(wr_ext_clr | ext_ack))
                      | {pin_event, 6'h00}) & pifm_pkg::EXT_MASK_BITS;
    end
  end

  // External mask; only the two pin enables are stored.
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      ext_mask_q <= pifm_pkg::REG_RESET;
    else if (I_WR && I_ADDR == pifm_pkg::EXTERNAL_IRQ_MASK_OFS)
      ext_mask_q <= I_WDATA & pifm_pkg::EXT_MASK_BITS;
  end

  // Timer mask; reserved positions are dropped at the write.
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      tmr_mask_q <= pifm_pkg::REG_RESET;
    else if (I_WR && I_ADDR == pifm_pkg::TIMER_IRQ_MASK_OFS)
      tmr_mask_q <= I_WDATA & pifm_pkg::TIMER_MASK_BITS;
  end

  // Sense control; the upper nibble belongs to other logic, reads zero.
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      ctrl_q <= pifm_pkg::REG_RESET;
    else if (I_WR && I_ADDR == pifm_pkg::CPU_CONTROL_REG_OFS)
      ctrl_q <= I_WDATA & pifm_pkg::CTRL_SENSE_BITS;
  end

  // Global enable: cleared when a vector is taken, set on return or by
  // software; taking wins, since the core is already entering a handler.
  assign take = I_IRQ_ACK;

  // Next value of the global enable.
  always_comb
  begin
    gie_d = gie_q;
    if (take)
      gie_d = 1'b0;
    else if (I_RETURN_FROM_IRQ || I_GLOBAL_EN_SET)
      gie_d = 1'b1;
  end

  // Global enable register.
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      gie_q <= 1'b0;
    else
      gie_q <= gie_d;
  end

  // Requests: level mode asks directly while the pin is low.
  assign ext_zero_req = (ext_flags_q[pifm_pkg::EXT_ZERO_BIT] | pin_level[0])
                        & ext_mask_q[pifm_pkg::EXT_ZERO_BIT];
  assign ext_one_req  = (ext_flags_q[pifm_pkg::EXT_ONE_BIT] | pin_level[1])
                        & ext_mask_q[pifm_pkg::EXT_ONE_BIT];

  // Pending and enabled terms in vector order: entry 0 is external zero,
  // entry 6 counter0 overflow. One vector keeps the selector a plain
  // scan and gives a single place to look when a source seems stuck.
  assign src_req[0] = ext_zero_req;
  assign src_req[1] = ext_one_req;
  assign src_req[2] = tmr_flags_q[pifm_pkg::CNT1_CAP_BIT] &
                      tmr_mask_q[pifm_pkg::CNT1_CAP_BIT];
  assign src_req[3] = tmr_flags_q[pifm_pkg::CNT1_CMP_A_BIT] &
                      tmr_mask_q[pifm_pkg::CNT1_CMP_A_BIT];
  assign src_req[4] = tmr_flags_q[pifm_pkg::CNT1_CMP_B_BIT] &
                      tmr_mask_q[pifm_pkg::CNT1_CMP_B_BIT];
  assign src_req[5] = tmr_flags_q[pifm_pkg::CNT1_OVF_BIT] &
                      tmr_mask_q[pifm_pkg::CNT1_OVF_BIT];
  assign src_req[6] = tmr_flags_q[pifm_pkg::CNT0_OVF_BIT] &
                      tmr_mask_q[pifm_pkg::CNT0_OVF_BIT];

  // Fixed priority by vector address, lowest address first.
  always_comb
  begin
    vec_d = pifm_pkg::VEC_NONE;
    if (src_req[0])
      vec_d = pifm_pkg::VEC_EXT_ZERO;
    else if (src_req[1])
      vec_d = pifm_pkg::VEC_EXT_ONE;
    else if (src_req[2])
      vec_d = pifm_pkg::VEC_CAPTURE;
    else if (src_req[3])
      vec_d = pifm_pkg::VEC_CMP_A;
    else if (src_req[4])
      vec_d = pifm_pkg::VEC_CMP_B;
    else if (src_req[5])
      vec_d = pifm_pkg::VEC_CNT1_OVF;
    else if (src_req[6])
      vec_d = pifm_pkg::VEC_CNT0_OVF;
  end

  // Request only with global enable; suppressed in the ack cycle so the
  // request falls one edge after the ack; the core still sees it in that cycle.
  assign req_d = gie_q && !take && !I_RETURN_FROM_IRQ &&
                 (vec_d != pifm_pkg::VEC_NONE);

  // Registered request; the core sees it one cycle after the selection.
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      O_IRQ_REQ <= 1'b0;
    else
      O_IRQ_REQ <= req_d;
  end

  // Registered vector; forced to the idle code without a request so the
  // bus never shows a stale source.
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      O_IRQ_VECTOR <= pifm_pkg::VEC_NONE;
    else
      O_IRQ_VECTOR <= req_d ? vec_d : pifm_pkg::VEC_NONE;
  end

  // Registered copy of the global enable for the core's status register.
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      O_GLOBAL_EN <= 1'b0;
    else
      O_GLOBAL_EN <= gie_q;
  end

  // Read data in the cycle after the read strobe; unmapped reads zero.
  always_comb
  begin
    rdata_d = 8'h00;
    unique case (I_ADDR)
      pifm_pkg::TIMER_IRQ_FLAGS_OFS:    rdata_d = tmr_flags_q;
      pifm_pkg::TIMER_IRQ_MASK_OFS:     rdata_d = tmr_mask_q;
      pifm_pkg::EXTERNAL_IRQ_MASK_OFS:  rdata_d = ext_mask_q;
      pifm_pkg::EXTERNAL_IRQ_FLAGS_OFS: rdata_d = ext_flags_q;
      pifm_pkg::CPU_CONTROL_REG_OFS:    rdata_d = ctrl_q;
      default:                          rdata_d = 8'h00;
    endcase
  end

  // Read port register; zero outside the answer cycle.
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      O_RDATA <= 8'h00;
    else if (I_RD)
      O_RDATA <= rdata_d;
    else
      O_RDATA <= 8'h00;
  end

endmodule // pifm_top

/* File: verif/pifm_asserts.sv */
// Port-level checks of the interrupt flag and mask block.
// Assumes one clock domain; bound to every instance of the block.
`timescale 1ns/1ps
module pifm_asserts
(
  input wire logic       I_CLK,
  input wire logic       I_ARST_N,
  input wire logic [5:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic       I_WR,
  input wire logic       I_RD,
  input wire logic [7:0] O_RDATA,
  input wire logic       I_RETURN_FROM_IRQ,
  input wire logic       I_IRQ_ACK,
  input wire logic       O_IRQ_REQ,
  input wire logic [4:0] O_IRQ_VECTOR,
  input wire logic       O_GLOBAL_EN
);
  // All checks share the core clock and its reset.
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);

  // Read data must be zero outside the cycle after a read.
  rd_idle_a: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
    else $error("read data not idle");
  ext_mask_rsvd_a: assert property (I_RD && I_ADDR == 6'h3B |=>
    O_RDATA[5:0] == 6'h00) else $error("mask reserved bits set");
  ext_flag_rsvd_a: assert property (I_RD && I_ADDR == 6'h3A |=>
    O_RDATA[5:0] == 6'h00) else $error("flag reserved bits set");
  tflag_rsvd_a: assert property (I_RD && I_ADDR == 6'h38 |=>
    (O_RDATA & 8'h15) == 8'h00) else $error("timer flag reserved set");
  // A write followed at once by a read must return the writable bits.
  tmask_wr_a: assert property (I_WR && I_ADDR == 6'h39 ##1
    I_RD && I_ADDR == 6'h39 |=> O_RDATA ==
    ($past(I_WDATA, 2) & pifm_pkg::TIMER_MASK_BITS))
    else $error("timer mask readback");
  emask_wr_a: assert property (I_WR && I_ADDR == 6'h3B ##1
    I_RD && I_ADDR == 6'h3B |=> O_RDATA ==
    ($past(I_WDATA, 2) & pifm_pkg::EXT_MASK_BITS))
    else $error("external mask readback");
  // Taking a vector drops the request and the global enable.
  ack_req_a: assert property (I_IRQ_ACK |=> !O_IRQ_REQ)
    else $error("request after ack");
  ack_gen_a: assert property (I_IRQ_ACK |-> ##[1:3] !O_GLOBAL_EN)
    else $error("enable kept after ack");
  ret_gen_a: assert property (I_RETURN_FROM_IRQ && !I_IRQ_ACK
    |-> ##[1:3] O_GLOBAL_EN) else $error("enable not restored");
  req_vec_a: assert property (O_IRQ_REQ |-> !O_IRQ_VECTOR[0] &&
    O_IRQ_VECTOR inside {[5'h02:5'h0E]}) else $error("bad vector");
endmodule // pifm_asserts

bind pifm_top pifm_asserts i_pifm_asserts (.I_CLK(I_CLK),
  .I_ARST_N(I_ARST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
  .I_RD(I_RD), .O_RDATA(O_RDATA), .I_RETURN_FROM_IRQ(I_RETURN_FROM_IRQ),
  .I_IRQ_ACK(I_IRQ_ACK), .O_IRQ_REQ(O_IRQ_REQ),
  .O_IRQ_VECTOR(O_IRQ_VECTOR), .O_GLOBAL_EN(O_GLOBAL_EN));

/* File: verif/pifm_core_model.sv */
// Core model: takes each offered vector, returns after a set delay.
// Assumes the block holds its request until it is acknowledged.
`timescale 1ns/1ps
module pifm_core_model
(
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_req,
  input  wire logic [4:0] i_vector,
  input  wire logic [3:0] i_delay,
  output logic            o_ack,
  output logic      [4:0] o_ack_vector,
  output logic            o_return
);
  logic [4:0] wait_q;

  // One ack per request; the vector bus toggles when it means nothing.
  // The handler lasts at least four cycles, as a real one would.
  always_ff @(posedge i_clk or negedge i_arst_n)
    if (!i_arst_n)
    begin
      o_ack        <= 1'b0;
      o_ack_vector <= 5'h00;
      o_return     <= 1'b0;
      wait_q       <= 5'h00;
    end
    else
    begin
      o_ack    <= 1'b0;
      o_return <= (wait_q == 5'h01);
      o_ack_vector <= ~o_ack_vector;
      if (wait_q != 5'h00)
        wait_q <= wait_q - 5'h01;
      else if (i_req && !o_ack && !o_return)
      begin
        o_ack        <= 1'b1;
        o_ack_vector <= i_vector;
        wait_q       <= {1'b0, i_delay} + 5'h04;
      end
    end
endmodule // pifm_core_model

/* File: verif/pifm_top_tb_top.sv */
// Bench: integer model of flags and masks checked at every read and ack.
// Assumes the block, the core model and the checker are compiled first.
`timescale 1ns/1ps
module pifm_top_tb_top;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [5:0]  addr = 6'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic [7:0]  ev = 8'h00;
  logic [1:0]  pins = 2'h3;
  logic [3:0]  dly = 4'h0;
  logic [7:0]  rdata;
  logic [4:0]  vec;
  logic [4:0]  ack_vec;
  logic        req;
  logic        ack;
  logic        ret;
  logic        gen;
  logic [1:0]  pv = 2'h3;
  logic [1:0]  pp = 2'h3;
  int          errors = 0;
  int          n_compared = 0;
  int          acks = 0;
  int          tf = 0;
  int          tm = 0;
  int          ef = 0;
  int          em = 0;
  int          ctl = 0;
  int          bit_i;
  int          dm;
  int unsigned seed = 21;
  logic [5:0]  amap[6] = '{6'h38, 6'h39, 6'h3A, 6'h3B, 6'h35, 6'h10};

  // A half period of 12.5 ns gives the 40 MHz core clock.
  always #12.5 clk = ~clk;

  pifm_top i_pifm_top (.I_CLK(clk), .I_ARST_N(arst_n), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata),
    .I_EXT_REQUEST_ONE(pins[1]), .I_EXT_REQUEST_ZERO(pins[0]),
    .I_CNT1_OVERFLOW(ev[7]), .I_CNT1_PWM_TURN(ev[2]),
    .I_CNT1_PWM_MODE(ev[4]), .I_CNT1_CMP_A_MATCH(ev[6]),
    .I_CNT1_CMP_B_MATCH(ev[5]), .I_CNT1_CAPTURE(ev[3]),
    .I_CNT0_OVERFLOW(ev[1]), .I_GLOBAL_EN_SET(ev[0]),
    .I_RETURN_FROM_IRQ(ret), .I_IRQ_ACK(ack), .I_ACK_VECTOR(ack_vec),
    .O_IRQ_REQ(req), .O_IRQ_VECTOR(vec), .O_GLOBAL_EN(gen));
  pifm_core_model i_pifm_core_model (.i_clk(clk), .i_arst_n(arst_n),
    .i_req(req), .i_vector(vec), .i_delay(dly), .o_ack(ack),
    .o_ack_vector(ack_vec), .o_return(ret));

  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  // Top pending source in vector order; a low pin in level mode counts.
  function automatic int topv(output int b);
    int p;
    int o[7] = '{14, 15, 3, 6, 5, 7, 1};
    p = (ctl & 3) == 0 && !pv[0] ? 'h40 : 0;
    p |= (ctl & 12) == 0 && !pv[1] ? 'h80 : 0;
    p = (((ef | p) & em) << 8) | (tf & tm);
    b = 0;
    for (int k = 0; k < 7; k++)
      if (p[o[k]])
      begin
        b = o[k];
        return 2 * k + 2;
      end
    return 0;
  endfunction

  task automatic chk(logic [7:0] got, int x);
    n_compared++;
    if (got !== x[7:0])
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, x[7:0]);
    end
  endtask

  // One bus cycle; the model takes clears first, then sets, then pin edges.
  task automatic cyc(bit w, bit r, logic [5:0] a, logic [7:0] d,
                     logic [7:0] e);
    int s;
    @(posedge clk);
    wr_s  <= w;
    rd_s  <= r;
    addr  <= a;
    wdata <= d;
    ev    <= e;
    pins  <= pv;
    dly   <= 4'(xs());
    if (w && a == 6'h38) tf &= ~int'(d);
    if (w && a == 6'h3A) ef &= ~int'(d);
    if (w && a == 6'h39) tm = d & 8'hEA;
    if (w && a == 6'h3B) em = d & 8'hC0;
    if (w && a == 6'h35) ctl = d & 8'h0F;
    tf |= {e[4] ? e[2] : e[7], e[6], e[5], 1'b0, e[3], 1'b0, e[1], 1'b0};
    for (int i = 0; i < 2; i++)
    begin
      s = (ctl >> (2 * i)) & 3;
      if ((s == 2 && pp[i] && !pv[i]) || (s == 3 && !pp[i] && pv[i]))
        ef |= 'h40 << i;
    end
    pp = pv;
  endtask

  task automatic rd(logic [5:0] a);
    int x;
    x = a == 6'h38 ? tf : a == 6'h39 ? tm : a == 6'h3A ? ef : 0;
    x = a == 6'h3B ? em : a == 6'h35 ? ctl : x;
    cyc(0, 1, a, 8'h00, 8'h00);
    cyc(0, 0, a, 8'h00, 8'h00);
    #1;
    chk(rdata, x);
  endtask

  task automatic conclude();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Every vector the core takes must be the top one; taking it clears it.
  // Looked at on the falling edge, where the ack has settled.
  always @(negedge clk)
    if (ack === 1'b1)
    begin
      chk({3'h0, ack_vec}, topv(bit_i));
      acks++;
      if (bit_i < 8)
        tf &= ~(1 << bit_i);
      else
        ef &= ~(1 << (bit_i - 8));
    end

  initial
  begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    foreach (amap[i]) rd(amap[i]);
    cyc(1, 0, 6'h39, 8'hFF, 8'h00);
    rd(6'h39);
    cyc(1, 0, 6'h3B, 8'hFF, 8'h00);
    rd(6'h3B);
    // Random timer events while the global enable is still off.
    repeat (40) cyc(0, 0, 6'h00, 8'h00, xs() & 8'hFE);
    rd(6'h38);
    cyc(1, 0, 6'h38, xs(), 8'h00);
    rd(6'h38);
    cyc(1, 0, 6'h38, 8'hFF, 8'hEA);
    rd(6'h38);
    // Each sense code with one pulse on both pins.
    for (int s = 0; s < 4; s++)
    begin
      cyc(1, 0, 6'h35, 8'(s * 5), 8'h00);
      pv = 2'h0;
      cyc(0, 0, 6'h00, 8'h00, 8'h00);
      pv = 2'h3;
      cyc(0, 0, 6'h00, 8'h00, 8'h00);
      rd(6'h3A);
      cyc(1, 0, 6'h3A, 8'hFF, 8'h00);
    end
    // A cleared flag stays clear while the pin remains low.
    cyc(1, 0, 6'h35, 8'h0A, 8'h00);
    pv = 2'h0;
    repeat (2) cyc(0, 0, 6'h00, 8'h00, 8'h00);
    cyc(1, 0, 6'h3A, 8'hFF, 8'h00);
    rd(6'h3A);
    pv = 2'h3;
    cyc(0, 0, 6'h00, 8'h00, 8'h00);
    pv = 2'h0;
    cyc(0, 0, 6'h00, 8'h00, 8'h00);
    // Enable and let the core drain seven pending sources.
    cyc(0, 0, 6'h00, 8'h00, 8'h01);
    for (int i = 0; i < 900 && topv(dm) != 0; i++)
      cyc(0, 0, 6'h00, 8'h00, 8'h00);
    chk(8'(topv(dm)), 0);
    rd(6'h38);
    // Level mode: the request repeats while the pin stays low.
    pv = 2'h2;
    cyc(0, 0, 6'h00, 8'h00, 8'h00);
    cyc(1, 0, 6'h35, 8'h00, 8'h00);
    dm = acks;
    for (int i = 0; i < 300 && acks < dm + 3; i++)
      cyc(0, 0, 6'h00, 8'h00, 8'h00);
    pv = 2'h3;
    repeat (30) cyc(0, 0, 6'h00, 8'h00, 8'h00);
    chk(8'(acks - dm >= 3), 1);
    rd(6'h3A);
    conclude();
  end
endmodule // pifm_top_tb_top
